/* File: vsms_pkg.sv */
/*
 Package for the slew-mode sequencer: timing, table constants,
 register map, state and level encodings, pin carrier struct.
 Assumes a 100 MHz core clock and pre-decoded multi-level pins.
*/
// Overview of operation
// - Soft-shutdown lowers code one step every four slew periods.
// - At zero code force low side on, high side off, reference off.
// - Undervoltage, overvoltage or thermal fault starts shutdown, sets fault latch.
// - Fault latch clears only by power-down toggle or supply below 1V.
// - Power-down low starts soft-shutdown to safe drives; skip, offset and on-time outputs still follow their pins.
// - Normal mode targets the table-selected VID code without offset.
// - Skip at reference or ground enters pulse skipping, blanks upper good threshold.
// - Deep-sleep window adds the offset steps to the VID code.
// - Suspend at reference or high uses suspend code, disables offset.
// - After enable and reference ready, ramp up from zero in steps.
// - Startup picks VID decoder if suspend is ground, else suspend decoder.
// - Table select high picks mobile table, low picks desktop table.
// - VID change while active starts a transition to the new level.
// - On-time and suspend code pins are static four-level inputs.
// - Suspend entry blanks good and undervoltage until 24 ticks after arrival.
// - Suspend at reference picks upper range, high picks lower range.
// - Power good freezes during transitions, resumes 24 ticks after final code.
// - Start and suspend moves go one step per slew period, shutdown one step per four.
// - Falling transitions take two extra slew periods.
// - Slew period programmable from 1.0us to 10us.
// - Power good stays low at least 3ms after power-up target reached.
// - Power-down falling drives power good low at once.
package vsms_pkg;

    // ======================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLEW_MIN_NS = 1000;
    localparam int SLEW_MAX_NS = 10000;
    localparam int SLEW_MIN_CYC = (SLEW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLEW_MAX_CYC = SLEW_MAX_NS / CLK_PERIOD_NS;
    localparam int PU_DELAY_US = 3000;
    localparam int PU_DELAY_CYC = (PU_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] DOWN_STEP_TICKS = 2'h3;
    localparam logic [4:0] BLANK_TICKS = 5'h18;
    localparam logic [1:0] FALL_SYNC_TICKS = 2'h2;

    // ======================================================
    // Code tables, in units of one 25mV step
    localparam int STEP_MV = 25;
    localparam logic [6:0] MOB_HI_TOP = 7'h46;
    localparam logic [6:0] MOB_LO_TOP = 7'h37;
    localparam logic [6:0] DSK_TOP = 7'h4a;
    localparam logic [4:0] VID_OFF_CODE = 5'h1f;
    localparam logic [6:0] SUS_UPPER_TOP = 7'h3a;
    localparam logic [6:0] SUS_LOWER_TOP = 7'h2a;

    // ======================================================
    // Register map (byte offsets) and reset values
    localparam logic [3:0] REG_SLEW_DIV = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [15:0] SLEW_DIV_RST = 16'h00c8;
    localparam int ST_POS_DAC = 0;
    localparam int ST_POS_GOOD = 8;
    localparam int ST_POS_FAULT = 9;
    localparam int ST_POS_STATE = 12;

    // ======================================================
    // Encodings
    typedef enum logic [1:0] {
        LVL_GND = 2'b00,
        LVL_REF = 2'b01,
        LVL_HIGH = 2'b10,
        LVL_OPEN = 2'b11
    } vsms_lvl_e;

    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_RAMP = 3'b001,
        ST_RUN = 3'b010,
        ST_DOWN = 3'b011,
        ST_PARK = 3'b100
    } vsms_state_e;

    // Pin bundle, already level-decoded by the analog front end
    typedef struct packed {
        logic power_down_n;
        logic ref_ok;
        logic supply_ok;
        logic table_select;
        vsms_lvl_e sus_level;
        vsms_lvl_e skip_level;
        vsms_lvl_e on_time_select;
        logic offset_window;
        logic [3:0] offset_input;
        logic [4:0] vid_bits;
        vsms_lvl_e [1:0] suspend_code_bits;
        logic undervoltage_trip;
        logic overvoltage_trip;
        logic thermal_trip;
        logic good_low_ok;
        logic good_high_ok;
    } vsms_pins_s;

endpackage

/* File: vsms_top.sv */
/*
 Slew-mode sequencer core: target selection, 25mV code stepping,
 soft start, soft shutdown, fault latch, power-good blanking and a
 small register port. Assumes pins arrive asynchronously as decoded
 level codes and that the analog DAC and gate drivers follow outputs.
*/
`timescale 1ns/100ps
module vsms_top #(
    parameter int PU_CYCLES = vsms_pkg::PU_DELAY_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire vsms_pkg::vsms_pins_s pins,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic [6:0] dac_code,
    output logic ref_enable,
    output logic switching_enable,
    output logic low_side_drive,
    output logic high_side_drive,
    output logic pulse_skip,
    output logic offset_enable,
    output logic fault_latched,
    output logic power_good,
    output logic [1:0] on_time_level
);
    import vsms_pkg::*;

    // ======================================================
    // Table decoders
    function automatic logic [6:0] vid_units(input logic mobile, input logic [4:0] d);
        logic [6:0] r;
        r = 7'h00;
        if (d == VID_OFF_CODE && !mobile) begin
            r = 7'h00;
        end else if (mobile && !d[4]) begin
            r = MOB_HI_TOP - {2'b00, d[3:0], 1'b0};
        end else if (mobile) begin
            r = MOB_LO_TOP - {2'b00, d};
        end else begin
            r = DSK_TOP - {2'b00, d};
        end
        return r;
    endfunction

    function automatic logic [6:0] sus_units(input logic lower, input vsms_lvl_e [1:0] s);
        logic [6:0] top;
        top = lower ? SUS_LOWER_TOP : SUS_UPPER_TOP;
        return top - {2'b00, s[1], s[0], 1'b0};
    endfunction

    // ======================================================
    // Pin synchronizers, two flops
    vsms_pins_s meta_q;
    vsms_pins_s pin_q;

    // Two-stage capture of all asynchronous pins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '0;
            pin_q <= '0;
        end else begin
            meta_q <= pins;
            pin_q <= meta_q;
        end
    end

    // ======================================================
    // Register port
    logic [15:0] slew_div_q;
    logic [15:0] rdata_q;
    vsms_state_e state_q;
    logic [6:0] dac_q;
    logic fault_q;
    logic good_q;

    // Slew divider write, clamped to the legal range
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            slew_div_q <= SLEW_DIV_RST;
        end else if (reg_wr && reg_addr == REG_SLEW_DIV) begin
            if (reg_wdata < 16'(SLEW_MIN_CYC)) begin
                slew_div_q <= 16'(SLEW_MIN_CYC);
            end else if (reg_wdata > 16'(SLEW_MAX_CYC)) begin
                slew_div_q <= 16'(SLEW_MAX_CYC);
            end else begin
                slew_div_q <= reg_wdata;
            end
        end
    end

    // Read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd && reg_addr == REG_SLEW_DIV) begin
            rdata_q <= slew_div_q;
        end else if (reg_rd && reg_addr == REG_STATUS) begin
            rdata_q <= 16'h0000;
            rdata_q[ST_POS_DAC +: 7] <= dac_q;
            rdata_q[ST_POS_GOOD] <= good_q;
            rdata_q[ST_POS_FAULT] <= fault_q;
            rdata_q[ST_POS_STATE +: 3] <= state_q;
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    // ======================================================
    // Slew clock tick
    logic [15:0] div_cnt_q;
    logic tick_q;

    // One-cycle tick every slew_div_q core cycles
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end else if (div_cnt_q >= slew_div_q - 16'h0001) begin
            div_cnt_q <= 16'h0000;
            tick_q <= 1'b1;
        end else begin
            div_cnt_q <= div_cnt_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    // ======================================================
    // Target selection
    logic suspend;
    logic skipping;
    logic use_offset;
    logic [6:0] vid_tgt;
    logic [6:0] tgt;

    assign suspend = pin_q.sus_level != LVL_GND;
    assign skipping = pin_q.skip_level == LVL_REF || pin_q.skip_level == LVL_GND;
    assign use_offset = !suspend && pin_q.offset_window;
    assign vid_tgt = vid_units(pin_q.table_select, pin_q.vid_bits);

    // Mux among VID, VID plus offset and suspend sources
    always_comb begin
        if (suspend) begin
            tgt = sus_units(pin_q.sus_level == LVL_HIGH, pin_q.suspend_code_bits);
        end else if (use_offset && vid_tgt != 7'h00) begin
            tgt = vid_tgt + {3'b000, pin_q.offset_input};
        end else begin
            tgt = vid_tgt;
        end
    end

    // ======================================================
    // Sequencer
    logic [1:0] wait_q;
    logic moving;
    logic [4:0] blank_q;
    logic blanked;
    logic fault_set;
    logic go_down;
    logic [18:0] pu_q;

    assign moving = dac_q != tgt;
    assign blanked = moving || blank_q != 5'h00;
    assign fault_set = (state_q == ST_RAMP || state_q == ST_RUN)
        && ((pin_q.undervoltage_trip && !blanked) || pin_q.overvoltage_trip
        || pin_q.thermal_trip);
    assign go_down = !pin_q.power_down_n || fault_q || fault_set;

    // State and stepped code
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_OFF;
            dac_q <= 7'h00;
            wait_q <= 2'h0;
        end else begin
            unique case (state_q)
                ST_OFF: begin
                    dac_q <= 7'h00;
                    wait_q <= 2'h0;
                    if (pin_q.power_down_n && !fault_q && pin_q.ref_ok) begin
                        state_q <= ST_RAMP;
                    end
                end
                ST_RAMP, ST_RUN: begin
                    if (go_down) begin
                        state_q <= ST_DOWN;
                        wait_q <= 2'h0;
                    end else if (tick_q) begin
                        if (dac_q < tgt) begin
                            dac_q <= dac_q + 7'h01;
                            wait_q <= 2'h0;
                        end else if (dac_q > tgt) begin
                            if (wait_q < FALL_SYNC_TICKS) begin
                                wait_q <= wait_q + 2'h1;
                            end else begin
                                dac_q <= dac_q - 7'h01;
                            end
                        end else begin
                            wait_q <= 2'h0;
                            state_q <= ST_RUN;
                        end
                    end
                end
                ST_DOWN: begin
                    if (tick_q) begin
                        if (dac_q == 7'h00) begin
                            state_q <= ST_PARK;
                        end else if (wait_q == DOWN_STEP_TICKS) begin
                            dac_q <= dac_q - 7'h01;
                            wait_q <= 2'h0;
                        end else begin
                            wait_q <= wait_q + 2'h1;
                        end
                    end
                end
                ST_PARK: begin
                    if (pin_q.power_down_n && !fault_q) begin
                        state_q <= ST_OFF;
                    end
                end
                default: begin
                    state_q <= ST_OFF;
                end
            endcase
        end
    end

    // Fault latch, set wins over clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_q <= 1'b0;
        end else if (fault_set) begin
            fault_q <= 1'b1;
        end else if (!pin_q.power_down_n || !pin_q.supply_ok) begin
            fault_q <= 1'b0;
        end
    end

    // Blanking counter, restarts while the code moves
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            blank_q <= 5'h00;
        end else if (moving) begin
            blank_q <= BLANK_TICKS;
        end else if (tick_q && blank_q != 5'h00) begin
            blank_q <= blank_q - 5'h01;
        end
    end

    // Power-up hold-off, counted from target reached
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pu_q <= 19'h00000;
        end else if (state_q != ST_RUN) begin
            pu_q <= 19'(PU_CYCLES);
        end else if (pu_q != 19'h00000) begin
            pu_q <= pu_q - 19'h00001;
        end
    end

    // Power good, frozen while blanked
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            good_q <= 1'b0;
        end else if (go_down || state_q != ST_RUN) begin
            good_q <= 1'b0;
        end else if (pu_q != 19'h00000) begin
            good_q <= 1'b0;
        end else if (!blanked) begin
            good_q <= pin_q.good_low_ok && (skipping || pin_q.good_high_ok);
        end
    end

    // ======================================================
    // Output registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_enable <= 1'b0;
            switching_enable <= 1'b0;
            low_side_drive <= 1'b1;
            high_side_drive <= 1'b0;
            pulse_skip <= 1'b0;
            offset_enable <= 1'b0;
            on_time_level <= 2'b00;
        end else begin
            // Reference stays up through the ramp-down, drops only once parked
            ref_enable <= state_q == ST_RAMP || state_q == ST_RUN || state_q == ST_DOWN
                || (state_q == ST_OFF && pin_q.power_down_n && !fault_q);
            switching_enable <= state_q == ST_RAMP || state_q == ST_RUN
                || state_q == ST_DOWN;
            low_side_drive <= state_q == ST_OFF || state_q == ST_PARK;
            high_side_drive <= 1'b0;
            pulse_skip <= skipping;
            offset_enable <= use_offset;
            on_time_level <= pin_q.on_time_select;
        end
    end

    assign reg_rdata = rdata_q;
    assign dac_code = dac_q;
    assign fault_latched = fault_q;
    assign power_good = good_q;

endmodule

/* File: vsms_host_model.sv */
/*
 Host model: drives the decoded pin bundle of the sequencer.
 Assumes the bench sets the wanted pin levels just after a clock edge.
*/
`timescale 1ns/100ps
module vsms_host_model
    import vsms_pkg::*;
(
    input wire logic clk,
    input wire vsms_pkg::vsms_pins_s want,
    output vsms_pkg::vsms_pins_s pins = '0
);
    // ======================================================
    // Pin drive
    // One edge moves every VID bit at once, zero skew
    // Four-level pins follow want too; the bench changes sus_level and skip_level mid-run
    always @(posedge clk) begin
        pins <= want;
    end
endmodule

/* File: vsms_properties.sv */
/*
 Checker for the sequencer's outputs against its pins.
 Assumes one clock domain and a slew tick of at least 100 cycles.
*/
`timescale 1ns/100ps
module vsms_properties
    import vsms_pkg::*;
#(
    parameter int PU_CYCLES = 50
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire vsms_pkg::vsms_pins_s pins,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [6:0] dac_code,
    input wire logic ref_enable,
    input wire logic switching_enable,
    input wire logic low_side_drive,
    input wire logic high_side_drive,
    input wire logic pulse_skip,
    input wire logic offset_enable,
    input wire logic fault_latched,
    input wire logic power_good,
    input wire logic [1:0] on_time_level
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ======================================================
    // Helpers: cycles since last code change, quiet history of clear pins
    logic [6:0] dac_q;
    logic [15:0] run_q;
    logic [3:0] quiet_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dac_q <= 7'h0;
            run_q <= 16'h0;
            quiet_q <= 4'h0;
        end else begin
            dac_q <= dac_code;
            run_q <= (dac_code != dac_q) ? 16'h0 : ((run_q == 16'hffff) ? run_q : run_q + 16'h1);
            quiet_q <= {quiet_q[2:0], pins.power_down_n & pins.supply_ok};
        end
    end
    sequence s_step;
        $changed(dac_code);
    endsequence
    sequence s_hold;
        $stable(dac_code)[*8];
    endsequence
    // ======================================================
    // Assertions
    chk_step_size: assert property (s_step |-> (dac_code == dac_q + 7'h1) || (dac_code == dac_q - 7'h1))
        else $error("code moved by more than one step");
    chk_step_hold: assert property (s_step |=> s_hold)
        else $error("code stepped faster than the slew tick");
    chk_park_safe: assert property ($fell(ref_enable) |-> dac_code == 7'h0 && low_side_drive && !switching_enable)
        else $error("reference off before zero code or drives unsafe");
    chk_high_off: assert property (!high_side_drive)
        else $error("high side drive asserted");
    chk_good_drop: assert property ($fell(pins.power_down_n) |-> ##[1:4] !power_good)
        else $error("power good not dropped on power down");
    chk_good_blank: assert property ($rose(power_good) |-> run_q >= 16'h0960)
        else $error("power good rose inside the blanking span");
    chk_fault_hold: assert property (fault_latched && quiet_q == 4'hf |=> fault_latched)
        else $error("fault latch cleared without a clearing event");
    chk_fault_norun: assert property (fault_latched && $past(fault_latched) |-> !$rose(switching_enable))
        else $error("restart while fault latched");
    chk_skip_mode: assert property ((pins.skip_level != LVL_HIGH)[*4] ##0 switching_enable |-> pulse_skip)
        else $error("pulse skip not entered");
    chk_sus_nooff: assert property ((pins.sus_level != LVL_GND)[*4] |-> !offset_enable)
        else $error("offset left on in suspend");
endmodule
bind vsms_top vsms_properties #(.PU_CYCLES(PU_CYCLES)) u_props (.clk, .reset_n, .pins, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .dac_code, .ref_enable, .switching_enable, .low_side_drive, .high_side_drive,
    .pulse_skip, .offset_enable, .fault_latched, .power_good, .on_time_level);

/* File: test_vid_slew_mode_sequencer.sv */
/*
 Self-checking bench: registers, ramps, mode changes, fault, shutdown.
 Assumes the host model drives pins and the checker is bound.
*/
`timescale 1ns/100ps
module test_vid_slew_mode_sequencer;
    import vsms_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    vsms_pins_s want;
    vsms_pins_s pins;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [6:0] dac_code;
    logic ref_enable, switching_enable, low_side_drive, high_side_drive, pulse_skip;
    logic offset_enable, fault_latched, power_good;
    logic [1:0] on_time_level;
    int fail_count = 0;
    int n_tests = 0;
    int n;
    vsms_host_model host (.clk, .want, .pins);
    vsms_top #(.PU_CYCLES(50)) DUT (.clk, .reset_n, .pins, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .dac_code, .ref_enable, .switching_enable, .low_side_drive, .high_side_drive, .pulse_skip,
        .offset_enable, .fault_latched, .power_good, .on_time_level);
    initial begin
        forever #5 clk = ~clk;
    end
    // ======================================================
    // Shared tasks
    task check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task reg_read(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask
    task automatic wait_for(ref logic s, input logic v, input int lim);
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(16'(n < lim), 16'h1);
    endtask
    task automatic wait_dac(input logic [6:0] v, input int lim);
        n = 0;
        while (dac_code !== v && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        check({9'h0, dac_code}, {9'h0, v});
    endtask
    task give_verdict;
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ======================================================
    // Scenarios
    task t_regs;
        check({low_side_drive, ref_enable, switching_enable, power_good}, 4'h8);
        reg_write(REG_SLEW_DIV, 16'h0001);
        reg_read(REG_SLEW_DIV, 16'h0064);
        reg_write(REG_SLEW_DIV, 16'h3000);
        reg_read(REG_SLEW_DIV, 16'h03e8);
        reg_write(REG_SLEW_DIV, 16'h0064);
        reg_read(4'h8, 16'h0000);
    endtask
    task t_power_up;
        @(posedge clk);
        want.power_down_n <= 1'b1;
        want.ref_ok <= 1'b1;
        wait_for(power_good, 1'b1, 12000);
        check({9'h0, dac_code}, 16'h002c);
        reg_read(REG_STATUS, 16'h212c);
        check({14'h0, on_time_level}, {14'h0, LVL_REF});
    endtask
    task t_fall;
        @(posedge clk);
        want.table_select <= 1'b1;
        want.vid_bits <= 5'h1f;
        wait_dac(7'h18, 3000);
        check(16'(n >= 2104 && n <= 2203), 16'h1);
        wait_for(power_good, 1'b1, 3000);
    endtask
    task t_modes;
        @(posedge clk);
        want.offset_window <= 1'b1;
        want.offset_input <= 4'h4;
        wait_dac(7'h1c, 1000);
        check(offset_enable, 1'b1);
        want.sus_level <= LVL_REF;
        repeat (8) @(posedge clk);
        #1;
        check(offset_enable, 1'b0);
        want.sus_level <= LVL_HIGH;
        wait_dac(7'h0c, 3000);
        want.undervoltage_trip <= 1'b1;
        repeat (20) @(posedge clk);
        want.undervoltage_trip <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check(fault_latched, 1'b0);
        want.sus_level <= LVL_GND;
        want.skip_level <= LVL_REF;
        repeat (8) @(posedge clk);
        #1;
        check(pulse_skip, 1'b1);
        wait_dac(7'h1c, 8000);
        wait_for(power_good, 1'b1, 3000);
    endtask
    task t_fault;
        @(posedge clk);
        want.overvoltage_trip <= 1'b1;
        wait_for(fault_latched, 1'b1, 10);
        want.overvoltage_trip <= 1'b0;
        wait_for(ref_enable, 1'b0, 14000);
        check({dac_code, low_side_drive, switching_enable}, 9'h002);
        repeat (200) @(posedge clk);
        #1;
        check({fault_latched, switching_enable}, 2'h2);
        want.power_down_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check(fault_latched, 1'b0);
        want.power_down_n <= 1'b1;
        wait_for(power_good, 1'b1, 8000);
    endtask
    task t_shutdown;
        @(posedge clk);
        want.power_down_n <= 1'b0;
        wait_for(power_good, 1'b0, 5);
        wait_for(ref_enable, 1'b0, 12000);
        check(16'(n >= 11202 && n <= 11301), 16'h1);
        check({dac_code, low_side_drive, switching_enable}, 9'h002);
    endtask
    // ======================================================
    // Main sequence and watchdog
    initial begin
        want = '0;
        want.supply_ok = 1'b1;
        want.skip_level = LVL_HIGH;
        want.on_time_select = LVL_REF;
        want.suspend_code_bits = {LVL_OPEN, LVL_OPEN};
        want.vid_bits = 5'h1e;
        want.good_low_ok = 1'b1;
        want.good_high_ok = 1'b1;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_power_up();
        t_fall();
        t_modes();
        t_fault();
        t_shutdown();
        give_verdict();
    end
    initial begin
        #900000;
        fail_count++;
        give_verdict();
    end
endmodule
